// ==== sfa_core.sv ====
// Purpose: frame aligner, deserializer and serializer core
// Assumes: serial clocks arrive as one-cycle bit enables on i_clock
// Notes: the falling edge of the parallel clock is the cycle it goes low
// Contract
// (R1) rising out-of-frame arms the search
// (R2) disarm once pattern found and input low
// (R3) armed search realigns the byte boundary
// (R4) disarmed: boundary frozen, aligned patterns only
// (R5) 48-bit match gives one-cycle frame pulse
// (R6) data and pulse change on falling edge
// (R7) deserializer delay 12 to 20 bits
// (R8) parallel clock never stretched on realign
// (R9) first received bit lands on bit 7
// (R10) transmit bit 7 first, nibble uses 7:4
// (R11) transmit word captured on parallel clock rise
// (R12) one transmit clock rise initialises datapath
// (R13) pass data only if one detect high
// (R14) width select sets both buses
// (R15) diagnostic loopback feeds transmitter to receiver
// (R16) line loopback feeds receiver to transmitter
// (R17) rate select picks slow or fast bits
// (R18) byte clock is bit clock over width
// (R19) byte clock static during master reset
// (R20) lock output follows synthesizer lock
// (R21) out-of-frame held one parallel period
// (R22) test inputs held low in service
// (R23) pattern is three A1 then three A2
// (R24) third A2 byte is first aligned byte
// (R25) reference select picks four frequencies
// (R26) A1 is f6, A2 is 28
// (R27) out-of-frame passes a two-stage synchroniser
//
// Decided for this implementation: the address map and the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
module sfa_core (
  // clock and master reset
  input wire logic i_clock,
  input wire logic i_reset,
  // avalon-mm slave
  input wire logic [sfa_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [sfa_pkg::DATA_W-1:0] i_avs_writedata,
  output logic [sfa_pkg::DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // receive line side
  input wire logic i_rx_serial_data,
  input wire logic i_rx_serial_clock,
  input wire logic i_signal_detect_diff_in,
  input wire logic i_signal_detect_logic_in,
  input wire logic i_out_of_frame_in,
  // receive parallel side
  output logic [7:0] o_rx_parallel_data,
  output logic o_rx_parallel_clock,
  output logic o_frame_pulse_out,
  // transmit parallel side
  input wire logic [7:0] i_tx_parallel_data,
  input wire logic i_tx_parallel_clock,
  // transmit line side
  output logic o_tx_serial_data,
  output logic o_tx_serial_clock,
  // synthesizer
  input wire logic i_synth_locked,
  output logic [1:0] o_ref_freq_sel,
  output logic o_pll_lock_indicator,
  output logic o_byte_rate_clock_out
);
  localparam logic [47:0] PATTERN = {{3{sfa_pkg::FRAME_A1}}, {3{sfa_pkg::FRAME_A2}}};

  logic [5:0] ctrl;
  logic bus_width_sel;
  logic rate_sel;
  logic diag_loopback_n;
  logic line_loopback_n;
  logic ack;
  logic [sfa_pkg::DATA_W-1:0] status_word;
  logic [15:0] frame_count;
  logic [1:0] rate_cnt;
  logic tx_bit_en;
  logic [2:0] tx_bit_cnt;
  logic [2:0] width_last;
  logic tx_load;
  logic tx_pclk_prev;
  logic [7:0] tx_hold;
  logic tx_init;
  logic [7:0] tx_shift;
  logic tx_bit;
  logic byte_clk;
  logic rx_bit_en;
  logic rx_raw;
  logic rx_bit;
  logic oof_meta;
  logic oof_sync;
  logic oof_prev;
  logic oof_rise;
  logic armed;
  logic found;
  logic [47:0] rx_shift;
  logic [47:0] next_rx_shift;
  logic [2:0] rx_bit_cnt;
  logic pattern_hit;
  logic byte_done;
  logic realign;
  logic [7:0] rx_byte;
  logic [7:0] rx_hold;
  logic hold_fp;
  logic [2:0] pclk_cnt;
  logic pclk_fall;

  assign bus_width_sel = ctrl[sfa_pkg::CTRL_BUS_WIDTH_BIT];
  assign rate_sel = ctrl[sfa_pkg::CTRL_RATE_BIT];
  assign diag_loopback_n = ctrl[sfa_pkg::CTRL_DIAG_LB_N_BIT];
  assign line_loopback_n = ctrl[sfa_pkg::CTRL_LINE_LB_N_BIT];
  // (R25) reference select drives synthesizer
  assign o_ref_freq_sel = ctrl[sfa_pkg::CTRL_REF_SEL_LSB +: 2];

  // avalon slave: one wait state, answer on the second edge
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack;
  always_ff @(posedge i_clock) begin
    if (i_reset | ack) begin
      ack <= 1'b0;
    end else begin
      ack <= i_avs_read | i_avs_write;
    end
  end

  // control register write, applied at the accepting edge
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      ctrl <= sfa_pkg::CTRL_RESET;
    end else if (i_avs_write & ack & (i_avs_address == sfa_pkg::CTRL_OFFSET)) begin
      ctrl <= i_avs_writedata[5:0];
    end
  end

  // status word built from live block state
  always_comb begin
    status_word = '0;
    status_word[sfa_pkg::STAT_ARMED_BIT] = armed;
    status_word[sfa_pkg::STAT_LOCK_BIT] = o_pll_lock_indicator;
    status_word[sfa_pkg::STAT_TX_INIT_BIT] = tx_init;
    status_word[sfa_pkg::STAT_FOUND_BIT] = found;
  end

  // read data is loaded one edge ahead so it stands at the answer edge
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_avs_readdata <= '0;
    end else if (i_avs_read & ~ack) begin
      unique case (i_avs_address)
        sfa_pkg::CTRL_OFFSET: o_avs_readdata <= {26'h0, ctrl};
        sfa_pkg::STATUS_OFFSET: o_avs_readdata <= status_word;
        sfa_pkg::FRAME_COUNT_OFFSET: o_avs_readdata <= {16'h0, frame_count};
        default: o_avs_readdata <= '0;
      endcase
    end
  end

  // (R17) bit enable: every cycle fast, one in four slow
  assign tx_bit_en = rate_sel | (rate_cnt == sfa_pkg::SLOW_RATE_DIV);
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rate_cnt <= '0;
    end else begin
      rate_cnt <= rate_cnt + 2'h1;
    end
  end

  // (R14) width select sets the word length for both directions
  assign width_last = bus_width_sel ? 3'h7 : 3'h3;

  // transmit bit counter marks the internal byte clock
  assign tx_load = tx_bit_en & (tx_bit_cnt == width_last);
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      tx_bit_cnt <= '0;
    end else if (tx_load) begin
      tx_bit_cnt <= '0;
    end else if (tx_bit_en) begin
      tx_bit_cnt <= tx_bit_cnt + 3'h1;
    end
  end

  // (R18) byte clock is high for the first half of each word
  // (R19) held low while reset is asserted
  assign byte_clk = ~i_reset & (tx_bit_cnt <= {1'b0, width_last[2:1]});
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_byte_rate_clock_out <= 1'b0;
    end else begin
      o_byte_rate_clock_out <= byte_clk;
    end
  end

  // (R11) capture the transmit word on each parallel clock rise
  // (R12) first rise after reset marks the datapath ready
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      tx_pclk_prev <= 1'b0;
      tx_hold <= '0;
      tx_init <= 1'b0;
    end else begin
      tx_pclk_prev <= i_tx_parallel_clock;
      if (i_tx_parallel_clock & ~tx_pclk_prev) begin
        tx_hold <= i_tx_parallel_data;
        tx_init <= 1'b1;
      end
    end
  end

  // (R10) shift out msb first; a nibble uses bits 7:4 only
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      tx_shift <= '0;
    end else if (tx_load) begin
      tx_shift <= tx_init ? tx_hold : 8'h00;
    end else if (tx_bit_en) begin
      tx_shift <= {tx_shift[6:0], 1'b0};
    end
  end
  assign tx_bit = tx_shift[7];

  // (R16) line loopback sends the received line straight back
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_tx_serial_data <= 1'b0;
      o_tx_serial_clock <= 1'b0;
    end else if (!line_loopback_n) begin
      o_tx_serial_data <= i_rx_serial_data;
      o_tx_serial_clock <= i_rx_serial_clock;
    end else begin
      o_tx_serial_data <= tx_bit;
      o_tx_serial_clock <= tx_bit_en;
    end
  end

  // (R20) lock indicator follows the synthesizer lock
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_pll_lock_indicator <= 1'b0;
    end else begin
      o_pll_lock_indicator <= i_synth_locked;
    end
  end

  // (R15) diagnostic loopback takes transmitter bits and clock
  assign rx_bit_en = diag_loopback_n ? i_rx_serial_clock : tx_bit_en;
  assign rx_raw = diag_loopback_n ? i_rx_serial_data : tx_bit;
  // (R13) data passes only with exactly one detect high
  assign rx_bit = rx_raw & (i_signal_detect_diff_in ^ i_signal_detect_logic_in);

  // (R27) two-stage synchroniser, edge taken after stage two
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      oof_meta <= 1'b0;
      oof_sync <= 1'b0;
      oof_prev <= 1'b0;
    end else begin
      oof_meta <= i_out_of_frame_in;
      oof_sync <= oof_meta;
      oof_prev <= oof_sync;
    end
  end
  assign oof_rise = oof_sync & ~oof_prev;

  // (R23) (R26) compare the last 48 bits with the framing pattern
  assign next_rx_shift = {rx_shift[46:0], rx_bit};
  assign pattern_hit = rx_bit_en & (next_rx_shift == PATTERN);
  assign byte_done = rx_bit_en & (rx_bit_cnt == width_last);
  // (R3) armed: a hit anywhere moves the boundary
  // (R4) disarmed: only a hit on the frozen boundary counts
  assign realign = pattern_hit & (armed | byte_done);

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rx_shift <= '0;
    end else if (rx_bit_en) begin
      rx_shift <= next_rx_shift;
    end
  end

  // boundary counter restarts after the last bit of the third A2
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rx_bit_cnt <= '0;
    end else if (realign | byte_done) begin
      rx_bit_cnt <= '0;
    end else if (rx_bit_en) begin
      rx_bit_cnt <= rx_bit_cnt + 3'h1;
    end
  end

  // (R1) rise arms; (R2) disarm after a hit and input low
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      armed <= 1'b0;
      found <= 1'b0;
    end else if (oof_rise) begin
      armed <= 1'b1;
      found <= 1'b0;
    end else begin
      if (armed & realign) begin
        found <= 1'b1;
      end
      if (armed & ~oof_sync & (found | realign)) begin
        armed <= 1'b0;
      end
    end
  end

  // (R9) first bit received sits on bit 7
  assign rx_byte = bus_width_sel ? next_rx_shift[7:0] : {next_rx_shift[3:0], 4'h0};

  // (R24) the third A2 is the first aligned word, tagged with the pulse
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rx_hold <= '0;
      hold_fp <= 1'b0;
    end else begin
      if (realign | byte_done) begin
        rx_hold <= rx_byte;
      end
      if (realign) begin
        hold_fp <= 1'b1;
      end else if (pclk_fall) begin
        hold_fp <= 1'b0;
      end
    end
  end

  // (R8) parallel clock counts received bits and ignores realignment
  assign pclk_fall = rx_bit_en & (pclk_cnt == {1'b0, width_last[2:1]});
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      pclk_cnt <= '0;
    end else if (rx_bit_en) begin
      pclk_cnt <= (pclk_cnt == width_last) ? 3'h0 : pclk_cnt + 3'h1;
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_rx_parallel_clock <= 1'b1;
    end else if (rx_bit_en) begin
      o_rx_parallel_clock <= (pclk_cnt == width_last) | (pclk_cnt < {1'b0, width_last[2:1]});
    end
  end

  // (R6) (R7) outputs change only as the parallel clock falls
  // (R5) pulse stands exactly one parallel clock period
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_rx_parallel_data <= '0;
      o_frame_pulse_out <= 1'b0;
    end else if (pclk_fall) begin
      o_rx_parallel_data <= rx_hold;
      o_frame_pulse_out <= hold_fp;
    end
  end

  // frame pulses seen, for software
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      frame_count <= '0;
    end else if (realign) begin
      frame_count <= frame_count + 16'h1;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  a_arm_on_rise: assert property (oof_rise |=> armed) // (R1)
    else $error("search not armed after out-of-frame rise");
  a_stay_armed: assert property (armed & oof_sync |=> armed) // (R2)
    else $error("search disarmed while out-of-frame high");
  a_disarm_cause: assert property ($fell(armed) |-> $past(found | realign) & ~$past(oof_sync)) // (R2)
    else $error("search disarmed without cause");
  a_realign_boundary: assert property (armed & pattern_hit |=> rx_bit_cnt == 3'h0) // (R3)
    else $error("boundary not moved on armed hit");
  a_frozen_boundary: assert property (~armed & pattern_hit & (rx_bit_cnt != width_last) |=> rx_bit_cnt == $past(rx_bit_cnt) + 3'h1) // (R4)
    else $error("unaligned hit flagged while disarmed");
  a_pulse_on_fall: assert property ($changed(o_frame_pulse_out) |-> $past(pclk_fall)) // (R6)
    else $error("frame pulse changed off the falling edge");
  a_data_on_fall: assert property ($changed(o_rx_parallel_data) |-> $past(pclk_fall)) // (R6)
    else $error("parallel data changed off the falling edge");
  a_pulse_follows: assert property (realign |-> ##[1:80] o_frame_pulse_out) // (R5)
    else $error("frame pulse missing after match");
  a_detect_gate: assert property (i_signal_detect_diff_in == i_signal_detect_logic_in |-> ~rx_bit) // (R13)
    else $error("data passed without valid signal detect");
  a_byte_clk_reset: assert property (disable iff (1'b0) i_reset |=> ~o_byte_rate_clock_out) // (R19)
    else $error("byte clock toggled in reset");
  a_lock_follow: assert property (o_pll_lock_indicator == $past(i_synth_locked)) // (R20)
    else $error("lock indicator out of step");
  a_tx_msb_first: assert property (tx_load & tx_init |=> tx_bit == $past(tx_hold[7])) // (R10)
    else $error("transmit did not start with bit 7");
  a_line_loop: assert property (!line_loopback_n |=> o_tx_serial_data == $past(i_rx_serial_data)) // (R16)
    else $error("line loopback data wrong");

  c_armed_hit: cover property (armed & realign);
  c_disarmed_hit: cover property (~armed & realign);
  c_disarm: cover property ($fell(armed));
  c_bus_read: cover property (i_avs_read & ~o_avs_waitrequest);
endmodule
`default_nettype wire

// ==== sfa_line_model.sv ====
// Purpose: line-side partner driving the recovered bit stream
// Assumes: bit clock is a one-cycle enable every gap+1 cycles
// Notes: data toggles between strobes so a stale bit never looks valid
`timescale 1ns/1ns
`default_nettype none
module sfa_line_model (
  // clock
  input wire logic i_clock,
  // recovered line
  output logic o_serial_data,
  output logic o_serial_clock
);
  int gap = 0;
  int cnt = 0;
  logic bits[$];
  // first bit queued is bit n-1 (bit 7 for a whole byte)
  task automatic push_bits(input int n, input logic [7:0] v);
    for (int i = n - 1; i >= 0; i--) begin
      bits.push_back(v[i]);
    end
  endtask
  initial begin
    o_serial_data = 1'b0;
    o_serial_clock = 1'b0;
  end
  // recovered clock runs free; whole filler bytes keep the byte grid
  always @(posedge i_clock) begin
    if (bits.size() == 0) begin
      push_bits(8, 8'h55);
    end
    if (cnt >= gap) begin
      cnt <= 0;
      o_serial_clock <= 1'b1;
      o_serial_data <= bits.pop_front();
    end else begin
      cnt <= cnt + 1;
      o_serial_clock <= 1'b0;
      o_serial_data <= ~o_serial_data; // stale bit is not held
    end
  end
endmodule
`default_nettype wire

// ==== sfa_pkg.sv ====
// Purpose: shared constants for the frame aligner core
// Assumes: one 10 MHz clock, bit rates carried as enable pulses
// Notes: register offsets are byte addresses on the Avalon-MM slave
package sfa_pkg;
  // bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  // register offsets
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [3:0] FRAME_COUNT_OFFSET = 4'h8;
  // control field positions
  localparam int CTRL_BUS_WIDTH_BIT = 0;
  localparam int CTRL_RATE_BIT = 1;
  localparam int CTRL_DIAG_LB_N_BIT = 2;
  localparam int CTRL_LINE_LB_N_BIT = 3;
  localparam int CTRL_REF_SEL_LSB = 4;
  // control reset value: 8-bit bus, fast rate, loopbacks off, 19.44 MHz ref
  localparam logic [5:0] CTRL_RESET = 6'h0f;
  // status field positions
  localparam int STAT_ARMED_BIT = 0;
  localparam int STAT_LOCK_BIT = 1;
  localparam int STAT_TX_INIT_BIT = 2;
  localparam int STAT_FOUND_BIT = 3;
  // framing bytes and pattern length
  localparam logic [7:0] FRAME_A1 = 8'hf6;
  localparam logic [7:0] FRAME_A2 = 8'h28;
  localparam int PATTERN_BITS = 48;
  // clock rate and bit rate divider
  localparam int CLOCK_PERIOD_NS = 100;
  localparam logic [1:0] SLOW_RATE_DIV = 2'h3; // 155.52 is a quarter of 622.08
  // reference select encodings
  localparam logic [1:0] REF_19M44 = 2'h0;
  localparam logic [1:0] REF_38M88 = 2'h1;
  localparam logic [1:0] REF_51M84 = 2'h2;
  localparam logic [1:0] REF_77M76 = 2'h3;
endpackage

// ==== sonet_serdes_frame_aligner_tb.sv ====
// Purpose: self-checking bench for the frame aligner core
// Assumes: fast rate and 8-bit bus unless a scenario changes them
// Notes: outputs are sampled on the falling clock edge, except bus read data and the lock and reset checks, taken on the rising edge
`timescale 1ns/1ns
`default_nettype none
module sonet_serdes_frame_aligner_tb;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic [3:0] i_avs_address = 4'h0;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  logic det_diff = 1'b1;
  logic det_logic = 1'b0;
  logic out_of_frame = 1'b0;
  logic [7:0] rx_data;
  logic rx_pclk, frame_pulse, tx_sd, tx_sclk, lock_ind, byte_clk, line_sd, line_sclk;
  logic [7:0] tx_data = 8'h00;
  logic tx_pclk = 1'b0;
  logic locked = 1'b0;
  logic [1:0] ref_sel;
  logic [31:0] rd;
  logic [23:0] sh;
  logic last_bclk = 1'b0;
  logic last_pclk = 1'b0;
  bit tx_follow = 0;
  bit mon_on = 0;
  int bad_count = 0;
  int check_count = 0;
  int per = 0;
  int bclk_rises = 0;
  int tx_strobes = 0;
  int w;
  logic [5:0] cfg[4] = '{6'h0f, 6'h0e, 6'h0d, 6'h07};
  int gp[4] = '{0, 0, 0, 3};
  int exp_tx[4] = '{64, 64, 16, 16};
  int exp_bc[4] = '{8, 16, 2, 8};

  always #50 i_clock = ~i_clock;

  sfa_core sfa_core_inst (
    .i_clock(i_clock), .i_reset(i_reset),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .i_rx_serial_data(line_sd), .i_rx_serial_clock(line_sclk),
    .i_signal_detect_diff_in(det_diff), .i_signal_detect_logic_in(det_logic),
    .i_out_of_frame_in(out_of_frame), .o_rx_parallel_data(rx_data),
    .o_rx_parallel_clock(rx_pclk), .o_frame_pulse_out(frame_pulse),
    .i_tx_parallel_data(tx_data), .i_tx_parallel_clock(tx_pclk),
    .o_tx_serial_data(tx_sd), .o_tx_serial_clock(tx_sclk),
    .i_synth_locked(locked), .o_ref_freq_sel(ref_sel),
    .o_pll_lock_indicator(lock_ind), .o_byte_rate_clock_out(byte_clk)
  );

  sfa_line_model line_inst (
    .i_clock(i_clock), .o_serial_data(line_sd), .o_serial_clock(line_sclk)
  );

  task automatic stop_test;
    $display("checks %0d, errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input bit ok, input string msg);
    check_count++;
    if (!ok) begin
      bad_count++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  // one avalon transfer, held until waitrequest is seen low
  task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clock);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 20);
    rd = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    if (n >= 20) begin
      check(0, "bus timeout");
      stop_test();
    end
  endtask

  // offset bits then three A1 and three A2 bytes
  task automatic push_frame(input int off);
    line_inst.push_bits(off, 8'h00);
    for (int i = 0; i < 6; i++) begin
      line_inst.push_bits(8, i < 3 ? sfa_pkg::FRAME_A1 : sfa_pkg::FRAME_A2);
    end
  endtask

  task automatic wait_pulse(input int lim);
    w = 0;
    do begin
      @(negedge i_clock);
      w++;
    end while (frame_pulse !== 1'b1 && w < lim);
  endtask

  function automatic bit has(input logic [23:0] s, input logic [7:0] v);
    for (int k = 0; k <= 16; k++) begin
      if (s[k+:8] === v) return 1;
    end
    return 0;
  endfunction

  task automatic grab_tx;
    sh = 24'h0;
    repeat (30) begin
      @(negedge i_clock);
      if (tx_sclk === 1'b1) sh = {sh[22:0], tx_sd};
    end
  endtask

  // upstream clocks its words with the byte clock
  // production-test inputs are not modelled and stay low
  always @(posedge i_clock) tx_pclk <= tx_follow ? byte_clk : 1'b0;

  // counters and parallel clock period monitor
  always @(negedge i_clock) begin
    last_bclk <= byte_clk;
    last_pclk <= rx_pclk;
    if (byte_clk === 1'b1 && last_bclk === 1'b0) bclk_rises++;
    if (tx_sclk === 1'b1) tx_strobes++;
    if (last_pclk === 1'b1 && rx_pclk === 1'b0) begin
      if (per > 0) check(per == 8, "parallel clock period changed");
      per = mon_on;
    end else if (per > 0) begin
      per++;
    end
  end

  initial begin
    repeat (10) @(posedge i_clock);
    i_reset <= 1'b0;
    av_xfer(0, sfa_pkg::CTRL_OFFSET, 32'h0);
    check(rd[5:0] === sfa_pkg::CTRL_RESET, "control reset value");
    av_xfer(1, 4'hc, 32'hffff_ffff);
    av_xfer(0, 4'hc, 32'h0);
    check(rd === 32'h0, "unmapped read not zero");
    locked <= 1'b1;
    av_xfer(0, sfa_pkg::STATUS_OFFSET, 32'h0);
    check(rd[1] === 1'b1 && lock_ind === 1'b1, "lock not shown");
    for (int r = 0; r < 4; r++) begin
      av_xfer(1, sfa_pkg::CTRL_OFFSET, {26'h0, r[1:0], 4'hf});
      @(negedge i_clock);
      check(ref_sel === r[1:0], "reference select");
    end
    // equal detects force zeros, so no pattern is seen
    mon_on = 1;
    det_logic <= 1'b1;
    // held far longer than a parallel period
    out_of_frame <= 1'b1;
    push_frame(3);
    wait_pulse(150);
    check(w == 150, "pulse with equal detects");
    det_logic <= 1'b0;
    push_frame(3);
    wait_pulse(300);
    check(w < 300 && rx_data === sfa_pkg::FRAME_A2, "first aligned byte");
    w = 0;
    while (frame_pulse === 1'b1 && w < 20) begin
      @(negedge i_clock);
      w++;
    end
    check(w == 8, "pulse width");
    av_xfer(0, sfa_pkg::STATUS_OFFSET, 32'h0);
    check(rd[0] === 1'b1, "search not armed");
    out_of_frame <= 1'b0;
    repeat (8) @(posedge i_clock);
    av_xfer(0, sfa_pkg::STATUS_OFFSET, 32'h0);
    check(rd[0] === 1'b0, "search still armed");
    push_frame(3);
    wait_pulse(250);
    check(w == 250, "off-boundary pattern flagged");
    push_frame(5);
    wait_pulse(250);
    check(w < 250, "on-boundary pattern missed");
    mon_on = 0;
    for (int c = 0; c < 4; c++) begin
      av_xfer(1, sfa_pkg::CTRL_OFFSET, {26'h0, cfg[c]});
      line_inst.gap = gp[c];
      repeat (8) @(posedge i_clock);
      tx_strobes = 0;
      bclk_rises = 0;
      repeat (64) @(posedge i_clock);
      check(tx_strobes >= exp_tx[c] - 1 && tx_strobes <= exp_tx[c] + 1, "bit rate");
      check(bclk_rises >= exp_bc[c] - 1 && bclk_rises <= exp_bc[c] + 1, "byte clock");
    end
    line_inst.gap = 0;
    av_xfer(1, sfa_pkg::CTRL_OFFSET, 32'h0f);
    tx_data <= 8'h16;
    grab_tx();
    check(sh === 24'h0, "word sent before capture");
    tx_follow = 1;
    repeat (30) @(posedge i_clock);
    grab_tx();
    check(has(sh, 8'h16), "transmit bit order");
    av_xfer(1, sfa_pkg::CTRL_OFFSET, 32'h0b);
    repeat (40) @(posedge i_clock);
    @(negedge i_clock);
    check(has({rx_data, rx_data, rx_data}, 8'h16), "diagnostic loopback");
    av_xfer(1, sfa_pkg::CTRL_OFFSET, 32'h0e);
    tx_data <= 8'hd2;
    repeat (30) @(posedge i_clock);
    grab_tx();
    check(has(sh, 8'hdd), "nibble transmit");
    i_reset <= 1'b1;
    bclk_rises = 0;
    repeat (10) @(posedge i_clock);
    check(bclk_rises == 0 && byte_clk === 1'b0, "byte clock in reset");
    i_reset <= 1'b0;
    stop_test();
  end
endmodule
`default_nettype wire
